// *** pkg/spm_cfg.svh ***
// Constants of the protection monitor: register offsets, field positions,
// reset values and timing counts. Definitions only.
`ifndef SPM_CFG_SVH
`define SPM_CFG_SVH
// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define SPM_OFF_CTRL 8'h00
`define SPM_OFF_FWD_LIM 8'h04
`define SPM_OFF_RFL_LIM 8'h08
`define SPM_OFF_GRACE 8'h0c
`define SPM_OFF_ENABLE 8'h10
`define SPM_OFF_EN_SEL 8'h14
`define SPM_OFF_EN_LEGACY 8'h18
`define SPM_OFF_STATUS 8'h1c
`define SPM_OFF_CLEAR 8'h20
`define SPM_OFF_IRQ_EN 8'h24
`define SPM_OFF_SETPOINT 8'h28
`define SPM_OFF_LIVE 8'h2c
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SPM_CTRL_RF_REQ 0
`define SPM_CTRL_AUTOGAIN 1
`define SPM_TYPE_TEMP 0
`define SPM_TYPE_WDOG 1
`define SPM_TYPE_RFL 2
`define SPM_TYPE_DISS 4
`define SPM_TYPE_FWD 9
`define SPM_ST_FWD_WRN 0
`define SPM_ST_FWD_SHD 1
`define SPM_ST_RFL_WRN 2
`define SPM_ST_RFL_SHD 3
`define SPM_ST_TMP_WRN 4
`define SPM_ST_TMP_SHD 5
`define SPM_ST_DIS_WRN 6
`define SPM_ST_DIS_SHD 7
`define SPM_ST_SHD_MASK 8'haa
// ----------------------------------------------------------------------
// Reset values (levels in hundredths of a dBm)
// ----------------------------------------------------------------------
`define SPM_RST_FWD_HIGH 16'h1284
`define SPM_RST_FWD_SHD 16'h12cf
`define SPM_RST_RFL_HIGH 16'h1275
`define SPM_RST_RFL_SHD 16'h1284
`define SPM_RST_ENABLE 10'h087
`define SPM_RST_GRACE 16'h0000
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SPM_CLK_HZ 50000000
`define SPM_MS_PER_S 1000
`define SPM_MS_CYC (`SPM_CLK_HZ / `SPM_MS_PER_S)
`endif

// *** pkg/spm_pkg.sv ***
// Types shared by the protection monitor files.
// Assumes the constants header is compiled alongside.
package spm_pkg;
    // A pair of levels, warning and shutdown
    typedef struct packed {
        logic [15:0] shd;
        logic [15:0] high;
    } spm_lim_s;
    // Level flags from the temperature and dissipation measurement logic
    typedef struct packed {
        logic diss_sd;
        logic diss_hi;
        logic temp_sd;
        logic temp_hi;
    } spm_ext_s;
    typedef logic [9:0] spm_en_t;
endpackage

// *** core/spm_grace.sv ***
// Persistence filter: passes a violation only after it has lasted longer
// than a grace period counted in millisecond ticks.
// Assumes tick_i is a one-cycle pulse from the same clock.
`timescale 1ns/100ps
module spm_grace (
    // Clock and control
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic tick_i,
    // Violation in, period, filtered out
    input wire logic viol_i,
    input wire logic [15:0] grace_i,
    output logic hit_o
);
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic hit_nxt;

    // Any break restarts timing; count saturates
    // R11 - restart on break
    assign cnt_nxt = !viol_i ? 16'h0000 : (tick_i && cnt_r != 16'hffff) ? cnt_r + 16'h0001 : cnt_r;
    assign hit_nxt = viol_i && (grace_i == 16'h0000 || cnt_r > grace_i);

    // Counter and filtered flag
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            cnt_r <= 16'h0000;
            hit_o <= 1'b0;
        end else if (ce_i) begin
            cnt_r <= cnt_nxt;
            hit_o <= hit_nxt;
        end
    end

    AST_GRACE_BREAK: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R11
        ce_i && !viol_i |=> !hit_o) else $error("grace output set without violation");
endmodule // spm_grace

// *** core/spm_monitor.sv ***
// Safe-operating-area protection monitor with an AXI4-Lite register slave.
// Assumes readings and level flags come from logic on mclk_i.
//
// Operation
// R1 - Forward above high: warn, RF stays
// R2 - Forward above shutdown: error, RF off
// R3 - Forward limits readable, high then shutdown
// R4 - Disabled protection type takes no action
// R5 - Type codes 0-9, enable 0/1
// R6 - Watchdog enable writes ignored, always on
// R7 - Per-type query returns type and enable
// R8 - Legacy readout gives types 0-7
// R9 - Legacy watchdog field always zero
// R10 - Temperature, reflection, current enabled by default
// R11 - Grace timer filters persistent violations only; forward violations bypass the grace timer
// R12 - Grace period in ms, write answered OK
// R13 - Reflection above high: warn, throttle
// R14 - Reflection above shutdown: error, RF off
// R15 - Autogain regulates reflected to high limit
// R16 - Reflection limits readable, high then shutdown
// R17 - Any enabled shutdown disables RF
// R18 - Status sticky until error clear
// R19 - Strictly greater than level violates
`timescale 1ns/100ps
`include "spm_cfg.svh"
module spm_monitor #(
    parameter int unsigned MS_CYC = `SPM_MS_CYC
) (
    // Clock, reset, enable
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Measurements
    input wire logic [15:0] fwd_pwr_i,
    input wire logic [15:0] rfl_pwr_i,
    input wire spm_pkg::spm_ext_s ext_i,
    // RF control, auto-gain and interrupt
    output logic rf_en_o,
    output logic agc_fb_rfl_o,
    output logic [15:0] agc_ref_o,
    output logic irq_o
);
    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a[7:2] == off[7:2]);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
        end
    endfunction

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [1:0] ctrl_r;
    spm_pkg::spm_lim_s fwd_lim_r;
    spm_pkg::spm_lim_s rfl_lim_r;
    logic [15:0] grace_r;
    spm_pkg::spm_en_t en_r;
    logic [3:0] sel_r;
    logic [7:0] stat_r;
    logic [7:0] ie_r;
    logic [15:0] setp_r;
    logic [31:0] ms_cnt_r;
    logic tick_r;

    // AXI state
    logic aw_hold_r;
    logic w_hold_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;

    // ------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------
    wire aw_hs = s_axi_awvalid_i && s_axi_awready_o;
    wire w_hs = s_axi_wvalid_i && s_axi_wready_o;
    wire aw_have = aw_hold_r || aw_hs;
    wire w_have = w_hold_r || w_hs;
    wire do_wr = aw_have && w_have && !s_axi_bvalid_o;
    wire [7:0] wa = aw_hold_r ? awaddr_r : s_axi_awaddr_i;
    wire [31:0] wd = w_hold_r ? wdata_r : s_axi_wdata_i;
    wire [3:0] ws = w_hold_r ? wstrb_r : s_axi_wstrb_i;
    wire aw_hold_nxt = aw_have && !do_wr;
    wire w_hold_nxt = w_have && !do_wr;
    wire bvalid_nxt = do_wr || (s_axi_bvalid_o && !s_axi_bready_i);

    // Per-register write strobes
    wire wr_ctrl = do_wr && hit(wa, `SPM_OFF_CTRL);
    wire wr_fwd = do_wr && hit(wa, `SPM_OFF_FWD_LIM);
    wire wr_rfl = do_wr && hit(wa, `SPM_OFF_RFL_LIM);
    wire wr_grace = do_wr && hit(wa, `SPM_OFF_GRACE);
    wire wr_en = do_wr && hit(wa, `SPM_OFF_ENABLE);
    wire wr_sel = do_wr && hit(wa, `SPM_OFF_EN_SEL);
    wire wr_clr = do_wr && hit(wa, `SPM_OFF_CLEAR);
    wire wr_ie = do_wr && hit(wa, `SPM_OFF_IRQ_EN);
    wire wr_setp = do_wr && hit(wa, `SPM_OFF_SETPOINT);
    wire wa_ok = wr_ctrl || wr_fwd || wr_rfl || wr_grace || wr_en || wr_sel || wr_clr || wr_ie || wr_setp;

    // Merged word for each write
    wire [31:0] m_ctrl = merge({30'h0, ctrl_r}, wd, ws);
    wire [31:0] m_fwd = merge(fwd_lim_r, wd, ws);
    wire [31:0] m_rfl = merge(rfl_lim_r, wd, ws);
    wire [31:0] m_grace = merge({16'h0, grace_r}, wd, ws);
    wire [31:0] m_en = merge({22'h0, en_r}, wd, ws);
    wire [31:0] m_sel = merge({28'h0, sel_r}, wd, ws);
    wire [31:0] m_ie = merge({24'h0, ie_r}, wd, ws);
    wire [31:0] m_setp = merge({16'h0, setp_r}, wd, ws);
    wire [7:0] clr_bits = wr_clr ? (wd[7:0] & {8{ws[0]}}) : 8'h00;

    // Enable write, the watchdog bit stays on whatever is written
    // R6 - watchdog forced on
    wire [9:0] en_wr = m_en[9:0] | (10'h001 << `SPM_TYPE_WDOG);

    // Handshake state; ready drops while a half-write waits
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o <= 1'b0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= 2'h0;
        end else if (ce_i) begin
            aw_hold_r <= aw_hold_nxt;
            w_hold_r <= w_hold_nxt;
            s_axi_awready_o <= !aw_hold_nxt;
            s_axi_wready_o <= !w_hold_nxt;
            s_axi_bvalid_o <= bvalid_nxt;
            // R12 - OKAY acknowledges write
            if (do_wr) begin
                s_axi_bresp_o <= wa_ok ? 2'h0 : 2'h2;
            end
        end
    end

    // Latched halves of a write
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else if (ce_i) begin
            if (aw_hs) begin
                awaddr_r <= s_axi_awaddr_i;
            end
            if (w_hs) begin
                wdata_r <= s_axi_wdata_i;
                wstrb_r <= s_axi_wstrb_i;
            end
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    // R10 - default enables
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            ctrl_r <= 2'h0;
            fwd_lim_r <= {`SPM_RST_FWD_SHD, `SPM_RST_FWD_HIGH};
            rfl_lim_r <= {`SPM_RST_RFL_SHD, `SPM_RST_RFL_HIGH};
            grace_r <= `SPM_RST_GRACE;
            en_r <= `SPM_RST_ENABLE;
            sel_r <= 4'h0;
            ie_r <= 8'h00;
            setp_r <= 16'h0000;
        end else if (ce_i) begin
            if (wr_ctrl) ctrl_r <= m_ctrl[1:0];
            if (wr_fwd) fwd_lim_r <= m_fwd;
            if (wr_rfl) rfl_lim_r <= m_rfl;
            if (wr_grace) grace_r <= m_grace[15:0];
            if (wr_en) en_r <= en_wr;
            if (wr_sel) sel_r <= m_sel[3:0];
            if (wr_ie) ie_r <= m_ie[7:0];
            if (wr_setp) setp_r <= m_setp[15:0];
        end
    end

    // ------------------------------------------------------------------
    // Millisecond tick for the grace timers
    // ------------------------------------------------------------------
    // One shared prescaler keeps the per-violation timers small
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            ms_cnt_r <= 32'h0000_0000;
            tick_r <= 1'b0;
        end else if (ce_i) begin
            tick_r <= (ms_cnt_r == 32'(MS_CYC - 1));
            ms_cnt_r <= (ms_cnt_r == 32'(MS_CYC - 1)) ? 32'h0000_0000 : ms_cnt_r + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------------
    // Violation detection
    // ------------------------------------------------------------------
    // R19 - strict greater-than compares
    wire fwd_hi = fwd_pwr_i > fwd_lim_r.high;
    wire fwd_sd = fwd_pwr_i > fwd_lim_r.shd;
    wire rfl_hi = rfl_pwr_i > rfl_lim_r.high;
    wire rfl_sd = rfl_pwr_i > rfl_lim_r.shd;

    // R4 - enable gates raw violations
    wire [5:0] raw = {ext_i.diss_sd & en_r[`SPM_TYPE_DISS], ext_i.diss_hi & en_r[`SPM_TYPE_DISS],
                      ext_i.temp_sd & en_r[`SPM_TYPE_TEMP], ext_i.temp_hi & en_r[`SPM_TYPE_TEMP],
                      rfl_sd & en_r[`SPM_TYPE_RFL], rfl_hi & en_r[`SPM_TYPE_RFL]};
    logic [5:0] held;

    // R11 - grace filter per reflection, temperature and dissipation violation
    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : gen_grace
            spm_grace u_grace (
                .mclk_i(mclk_i),
                .rstn_i(rstn_i),
                .ce_i(ce_i),
                .tick_i(tick_r),
                .viol_i(raw[g]),
                .grace_i(grace_r),
                .hit_o(held[g])
            );
        end
    endgenerate

    // Events; a warning is raised only while the matching shutdown event is not
    logic [7:0] ev;
    always_comb begin
        ev = 8'h00;
        // R1 - forward warning
        ev[`SPM_ST_FWD_WRN] = en_r[`SPM_TYPE_FWD] && fwd_hi && !fwd_sd;
        // R2 - forward shutdown
        ev[`SPM_ST_FWD_SHD] = en_r[`SPM_TYPE_FWD] && fwd_sd;
        // R13 - reflection warning
        ev[`SPM_ST_RFL_WRN] = held[0] && !held[1];
        // R14 - reflection shutdown
        ev[`SPM_ST_RFL_SHD] = held[1];
        ev[`SPM_ST_TMP_WRN] = held[2] && !held[3];
        ev[`SPM_ST_TMP_SHD] = held[3];
        ev[`SPM_ST_DIS_WRN] = held[4] && !held[5];
        ev[`SPM_ST_DIS_SHD] = held[5];
    end

    // R18 - sticky until clear, set wins
    wire [7:0] stat_nxt = (stat_r & ~clr_bits) | ev;
    // R17 - any shutdown blocks RF
    wire rf_nxt = ctrl_r[`SPM_CTRL_RF_REQ] && ((stat_nxt & `SPM_ST_SHD_MASK) == 8'h00);
    // R15 - reflected feedback while above high
    wire thr_nxt = ctrl_r[`SPM_CTRL_AUTOGAIN] && en_r[`SPM_TYPE_RFL] && rfl_hi;

    // Status, RF gate, auto-gain target and interrupt
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            stat_r <= 8'h00;
            rf_en_o <= 1'b0;
            agc_fb_rfl_o <= 1'b0;
            agc_ref_o <= 16'h0000;
            irq_o <= 1'b0;
        end else if (ce_i) begin
            stat_r <= stat_nxt;
            rf_en_o <= rf_nxt;
            agc_fb_rfl_o <= thr_nxt;
            agc_ref_o <= thr_nxt ? rfl_lim_r.high : setp_r;
            irq_o <= (stat_nxt & ie_r) != 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    wire ar_hs = s_axi_arvalid_i && s_axi_arready_o;
    wire [7:0] ra = s_axi_araddr_i;
    // R9 - legacy watchdog field zero
    wire [7:0] legacy = en_r[7:0] & ~(8'h01 << `SPM_TYPE_WDOG);
    // R5 - codes above 9 read off
    // R7 - selected type enable
    wire sel_en = (sel_r <= 4'h9) ? en_r[sel_r] : 1'b0;
    wire ra_ok = hit(ra, `SPM_OFF_CTRL) || hit(ra, `SPM_OFF_FWD_LIM) || hit(ra, `SPM_OFF_RFL_LIM)
                 || hit(ra, `SPM_OFF_GRACE) || hit(ra, `SPM_OFF_ENABLE) || hit(ra, `SPM_OFF_EN_SEL)
                 || hit(ra, `SPM_OFF_EN_LEGACY) || hit(ra, `SPM_OFF_STATUS) || hit(ra, `SPM_OFF_CLEAR)
                 || hit(ra, `SPM_OFF_IRQ_EN) || hit(ra, `SPM_OFF_SETPOINT) || hit(ra, `SPM_OFF_LIVE);

    // R3 - forward limits word; R16 - reflection limits word; R8 - legacy byte
    logic [31:0] rd;
    always_comb begin
        rd = 32'h0000_0000;
        if (hit(ra, `SPM_OFF_CTRL)) rd = {30'h0, ctrl_r};
        if (hit(ra, `SPM_OFF_FWD_LIM)) rd = fwd_lim_r;
        if (hit(ra, `SPM_OFF_RFL_LIM)) rd = rfl_lim_r;
        if (hit(ra, `SPM_OFF_GRACE)) rd = {16'h0, grace_r};
        if (hit(ra, `SPM_OFF_ENABLE)) rd = {22'h0, en_r};
        if (hit(ra, `SPM_OFF_EN_SEL)) rd = {23'h0, sel_en, 4'h0, sel_r};
        if (hit(ra, `SPM_OFF_EN_LEGACY)) rd = {24'h0, legacy};
        if (hit(ra, `SPM_OFF_STATUS)) rd = {24'h0, stat_r};
        if (hit(ra, `SPM_OFF_IRQ_EN)) rd = {24'h0, ie_r};
        if (hit(ra, `SPM_OFF_SETPOINT)) rd = {16'h0, setp_r};
        if (hit(ra, `SPM_OFF_LIVE)) rd = {29'h0, irq_o, agc_fb_rfl_o, rf_en_o};
    end

    wire rvalid_nxt = ar_hs || (s_axi_rvalid_o && !s_axi_rready_i);

    // Read data is captured once and held until taken
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= 2'h0;
        end else if (ce_i) begin
            s_axi_arready_o <= !rvalid_nxt;
            s_axi_rvalid_o <= rvalid_nxt;
            if (ar_hs) begin
                s_axi_rdata_o <= rd;
                s_axi_rresp_o <= ra_ok ? 2'h0 : 2'h2;
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    AST_FWD_WARN: assert property (ce_i && en_r[9] && fwd_hi && !fwd_sd |=> stat_r[0]) // R1
        else $error("forward warning not raised");
    AST_FWD_SHD: assert property (ce_i && en_r[9] && fwd_sd |=> stat_r[1] && !rf_en_o) // R2
        else $error("forward shutdown did not drop RF");
    AST_FWD_OFF: assert property (ce_i && !en_r[9] && !stat_r[1] |=> !stat_r[1]) // R4
        else $error("disabled forward protection acted");
    AST_WDOG_ON: assert property (ce_i |=> en_r[1]) // R6
        else $error("watchdog enable cleared");
    AST_LEGACY: assert property ($rose(s_axi_rvalid_o) && $past(hit(ra, `SPM_OFF_EN_LEGACY)) // R9
        |-> s_axi_rdata_o[1] == 1'b0 && s_axi_rdata_o[31:8] == 24'h0)
        else $error("legacy readout shows watchdog");
    AST_STICKY: assert property (ce_i |=> (stat_r & $past(stat_r & ~clr_bits)) == $past(stat_r & ~clr_bits)) // R18
        else $error("status bit lost without clear");
    AST_THROTTLE: assert property (thr_nxt && ce_i |=> agc_fb_rfl_o && agc_ref_o == $past(rfl_lim_r.high)) // R15
        else $error("auto-gain not throttled to reflection limit");
    AST_RFL_SHD: assert property (ce_i && held[1] |=> stat_r[3] && !rf_en_o) // R14
        else $error("reflection shutdown did not drop RF");

    COV_FWD_SHD: cover property (ce_i && en_r[9] && fwd_sd ##1 !rf_en_o);
    COV_CLEAR: cover property (stat_r != 8'h00 ##1 stat_r == 8'h00);
    COV_THROTTLE: cover property (agc_fb_rfl_o ##[1:20] !agc_fb_rfl_o);
endmodule // spm_monitor

// *** bench/spm_host_model.sv ***
// Host model: register master speaking AXI4-Lite to the monitor.
// Assumes one clock shared with the monitor; called by the bench top.
`timescale 1ns/100ps
module spm_host_model (
    // Clock
    input wire logic mclk_i,
    // Write channels
    output logic [7:0] awaddr_o,
    output logic awvalid_o,
    input wire logic awready_i,
    output logic [31:0] wdata_o,
    output logic wvalid_o,
    input wire logic wready_i,
    input wire logic [1:0] bresp_i,
    input wire logic bvalid_i,
    output logic bready_o,
    // Read channels
    output logic [7:0] araddr_o,
    output logic arvalid_o,
    input wire logic arready_i,
    input wire logic [31:0] rdata_i,
    input wire logic [1:0] rresp_i,
    input wire logic rvalid_i,
    output logic rready_o
);
    initial begin
        {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
        {araddr_o, arvalid_o, rready_o} = '0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        awaddr_o <= a;
        wdata_o <= d;
        awvalid_o <= 1'b1;
        wvalid_o <= 1'b1;
        bready_o <= 1'b1;
        do begin
            @(posedge mclk_i);
            if (awready_i) awvalid_o <= 1'b0;
            if (wready_i) wvalid_o <= 1'b0;
        end while (!bvalid_i);
        r = bresp_i;
        bready_o <= 1'b0;
        // Extra edge so the next call never reassigns in this step
        @(posedge mclk_i);
    endtask
    // Read one word, holding the request until it is taken
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr_o <= a;
        arvalid_o <= 1'b1;
        rready_o <= 1'b1;
        do begin
            @(posedge mclk_i);
            if (arready_i) arvalid_o <= 1'b0;
        end while (!rvalid_i);
        d = rdata_i;
        r = rresp_i;
        rready_o <= 1'b0;
        @(posedge mclk_i);
    endtask
endmodule // spm_host_model

// *** bench/spm_monitor_tb_top.sv ***
// Self-checking bench for the protection monitor.
// Assumes the host model above and the constants header on the include path.
`timescale 1ns/100ps
`include "spm_cfg.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
    $display("[FAIL] %0t got %h expected %h", $time, a, b); end end
module spm_monitor_tb_top;
    logic mclk_i, rstn_i, ce_i;
    logic [7:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic [15:0] fwd_pwr, rfl_pwr, agc_ref;
    spm_pkg::spm_ext_s ext;
    logic rf_en, agc_fb, irq;
    int errors = 0, tests_run = 0, cyc = 0;
    // ----------------------------------------------------------------
    // Clock, design, host
    // ----------------------------------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end
    // Short millisecond so grace periods fit the run
    spm_monitor #(.MS_CYC(4)) i_dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .fwd_pwr_i(fwd_pwr), .rfl_pwr_i(rfl_pwr), .ext_i(ext), .rf_en_o(rf_en),
        .agc_fb_rfl_o(agc_fb), .agc_ref_o(agc_ref), .irq_o(irq));
    spm_host_model i_host (.mclk_i(mclk_i), .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready),
        .wdata_o(wdata), .wvalid_o(wvalid), .wready_i(wready), .bresp_i(bresp), .bvalid_i(bvalid),
        .bready_o(bready), .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready),
        .rdata_i(rdata), .rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready));
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        i_host.rd(a, d, r);
        `CHK(d, e)
        `CHK(r, 2'h0)
    endtask
    task automatic wrc(input logic [7:0] a, input logic [31:0] v);
        i_host.wr(a, v, r);
        `CHK(r, 2'h0)
    endtask
    task automatic report_and_stop;
        if (errors == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Hang guard, well above the expected few hundred cycles
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            report_and_stop();
        end
    end
    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        rstn_i = 1'b0; ce_i = 1'b1; fwd_pwr = '0; rfl_pwr = '0; ext = '0;
        repeat (3) @(posedge mclk_i);
        rstn_i <= 1'b1;
        @(posedge mclk_i);
        rdc(`SPM_OFF_FWD_LIM, 32'h12cf1284);
        rdc(`SPM_OFF_RFL_LIM, 32'h12841275);
        rdc(`SPM_OFF_ENABLE, 32'h087);
        rdc(`SPM_OFF_EN_LEGACY, 32'h085);
        wrc(`SPM_OFF_ENABLE, 32'h0);
        rdc(`SPM_OFF_ENABLE, 32'h002);
        wrc(`SPM_OFF_ENABLE, 32'h3ff);
        rdc(`SPM_OFF_EN_LEGACY, 32'h0fd);
        // Every type code reads back its own enable
        for (int t = 0; t < 11; t++) begin
            wrc(`SPM_OFF_EN_SEL, t);
            rdc(`SPM_OFF_EN_SEL, (t < 10) ? (32'h100 | t) : t);
        end
        i_host.rd(8'h30, d, r);
        `CHK(r, 2'h2)
        i_host.wr(`SPM_OFF_EN_LEGACY, 32'h0, r);
        `CHK(r, 2'h2)
        wrc(`SPM_OFF_ENABLE, 32'h287);
        wrc(`SPM_OFF_IRQ_EN, 32'hff);
        wrc(`SPM_OFF_CTRL, 32'h3);
        // Forward power: equal, above high, above shutdown
        fwd_pwr <= 16'h1284;
        repeat (4) @(posedge mclk_i);
        rdc(`SPM_OFF_STATUS, 32'h0);
        fwd_pwr <= 16'h1285;
        repeat (4) @(posedge mclk_i);
        `CHK(rf_en, 1'b1)
        `CHK(irq, 1'b1)
        rdc(`SPM_OFF_STATUS, 32'h1);
        fwd_pwr <= 16'h12d0;
        repeat (4) @(posedge mclk_i);
        `CHK(rf_en, 1'b0)
        rdc(`SPM_OFF_STATUS, 32'h3);
        fwd_pwr <= 16'h0;
        repeat (4) @(posedge mclk_i);
        rdc(`SPM_OFF_STATUS, 32'h3);
        wrc(`SPM_OFF_CLEAR, 32'hff);
        repeat (4) @(posedge mclk_i);
        `CHK(rf_en, 1'b1)
        `CHK(irq, 1'b0)
        // Forward type disabled: no reaction
        wrc(`SPM_OFF_ENABLE, 32'h087);
        fwd_pwr <= 16'h12d0;
        repeat (4) @(posedge mclk_i);
        `CHK(rf_en, 1'b1)
        rdc(`SPM_OFF_STATUS, 32'h0);
        fwd_pwr <= 16'h0;
        // Reflection with a 2 ms grace: short burst is tolerated
        wrc(`SPM_OFF_GRACE, 32'h2);
        wrc(`SPM_OFF_SETPOINT, 32'h1200);
        rfl_pwr <= 16'h1276;
        repeat (3) @(posedge mclk_i);
        `CHK(agc_fb, 1'b1)
        `CHK(agc_ref, 16'h1275)
        rfl_pwr <= 16'h0;
        repeat (20) @(posedge mclk_i);
        rdc(`SPM_OFF_STATUS, 32'h0);
        rfl_pwr <= 16'h1276;
        repeat (20) @(posedge mclk_i);
        rdc(`SPM_OFF_STATUS, 32'h4);
        rfl_pwr <= 16'h1285;
        repeat (20) @(posedge mclk_i);
        `CHK(rf_en, 1'b0)
        rdc(`SPM_OFF_STATUS, 32'hc);
        rfl_pwr <= 16'h0;
        repeat (4) @(posedge mclk_i);
        wrc(`SPM_OFF_CLEAR, 32'hff);
        repeat (4) @(posedge mclk_i);
        `CHK(agc_fb, 1'b0)
        `CHK(agc_ref, 16'h1200)
        `CHK(rf_en, 1'b1)
        // Clock enable low freezes the grace timers, then temperature trips
        ce_i <= 1'b0;
        ext <= 4'h2;
        repeat (20) @(posedge mclk_i);
        `CHK(rf_en, 1'b1)
        ce_i <= 1'b1;
        repeat (20) @(posedge mclk_i);
        `CHK(rf_en, 1'b0)
        rdc(`SPM_OFF_LIVE, 32'h4);
        rdc(`SPM_OFF_STATUS, 32'h20);
        ext <= 4'h0;
        repeat (4) @(posedge mclk_i);
        wrc(`SPM_OFF_CLEAR, 32'hff);
        repeat (4) @(posedge mclk_i);
        `CHK(rf_en, 1'b1)
        // Mid-run reset brings the grace period back to zero
        rstn_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        rstn_i <= 1'b1;
        @(posedge mclk_i);
        rdc(`SPM_OFF_GRACE, 32'h0);
        report_and_stop();
    end
endmodule // spm_monitor_tb_top
